/* File: ssc_pkg.sv */
// Package: register map, field layout and constants of the stepper control bank
package ssc_pkg;
	localparam logic [4:0] ADDR_WATCHDOG_CONTROL  = 5'h00;
	localparam logic [4:0] ADDR_STEP_CURRENT_CTRL = 5'h01;
	localparam logic [4:0] ADDR_DIRECTION_PWM     = 5'h02;
	localparam logic [4:0] ADDR_DRIVER_SLEEP_LA   = 5'h03;
	localparam logic [4:0] ADDR_PWM_STROBE        = 5'h08;
	localparam logic [4:0] ADDR_STATUS_FIRST      = 5'h04;
	localparam logic [4:0] ADDR_STATUS_LAST       = 5'h07;
	localparam logic [7:0] CTRL_RESET_VALUE       = 8'h00;
	// Bits kept in each control register, others read zero
	localparam logic [7:0] MASK_WATCHDOG          = 8'hf8;
	localparam logic [7:0] MASK_STEP_CURRENT      = 8'hff;
	localparam logic [7:0] MASK_DIRECTION_PWM     = 8'hcf;
	localparam logic [7:0] MASK_DRIVER_SLEEP      = 8'hf0;
	localparam logic [7:0] MASK_PWM_STROBE        = 8'hf7;
	localparam int         BITS_PER_BYTE          = 8;
	localparam int         WRITE_PACKET_BITS      = 16;
	localparam int         WATCHDOG_BASE_MS       = 32;
	// Mask comparator and compensation bridge lengths, then switch duties; the code 00 length is the reset default
	localparam logic [4:0] MASK_TIME_00           = 5'h04;
	localparam logic [4:0] MASK_TIME_01           = 5'h08;
	localparam logic [4:0] MASK_TIME_10           = 5'h0c;
	localparam logic [4:0] MASK_TIME_11           = 5'h13;
	localparam logic [4:0] COMP_TIME_00           = 5'h04;
	localparam logic [4:0] COMP_TIME_01           = 5'h08;
	localparam logic [4:0] COMP_TIME_10           = 5'h0c;
	localparam logic [4:0] COMP_TIME_11           = 5'h13;
	localparam logic [6:0] DUTY_SWITCH_0          = 7'h56;
	localparam logic [6:0] DUTY_SWITCH_1          = 7'h4b;

	typedef enum logic [1:0] {
		SLOPE_VERY_FAST = 2'h0,
		SLOPE_FAST      = 2'h1,
		SLOPE_SLOW      = 2'h2,
		SLOPE_VERY_SLOW = 2'h3
	} ssc_slope_type;

	// Decoded controls handed to the driver core
	typedef struct packed {
		logic          watchdog_enable;
		logic [3:0]    watchdog_timeout_sel;
		logic [9:0]    watchdog_timeout_ms;
		logic [2:0]    step_resolution_sel;
		logic [4:0]    peak_current_sel;
		ssc_slope_type slope_sel;
		logic          pwm_double_freq;
		logic          pwm_jitter_en;
		logic          load_angle_transparent;
		logic          load_angle_gain_quarter;
		logic          driver_enable;
		logic          sleep_enable;
		logic [1:0]    pwm_mode_sel;
		logic [4:0]    mask_comparator_cycles;
		logic [6:0]    switch_duty_percent;
		logic [4:0]    comp_bridge_cycles;
	} ssc_ctrl_type;

	// Synchronised serial pins
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} ssc_serial_type;
endpackage : ssc_pkg

/* File: ssc_regs.sv */
// Serial control-register bank of the stepper driver
//
// Functional notes
// [R01] Write shifts out old register contents
// [R02] Readback returns old value, new next byte; code repeats the old value in the next frame's first byte
// [R03] Status sampled only while select high
// [R04] Transmit buffer loaded on eighth falling edge
// [R05] Control registers read/write, reset to zero
// [R06] Direction is pin xor invert bit
// [R07] Step edge polarity chosen by bit
// [R08] Slope field selects four switching slopes
// [R09] Load angle transparent when bit clear
// [R10] Load angle gain half or quarter
// [R11] PWM frequency default or doubled
// [R12] Driver outputs follow enable bit
// [R13] Mask comparator time from two-bit field
// [R14] Switch duty 86 or 75 percent
// [R15] Compensation bridge time from two-bit field
// [R16] First byte: command bit, five-bit address
// [R17] Write must be exactly sixteen bits
// [R18] Write commits after select rises
// [R19] Watchdog timeout 32 ms times (sel+1)
// [R20] Unused bits ignore writes, read zero
`timescale 1ns/10ps
module ssc_regs
	import ssc_pkg::*;
(
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         clk_en_i,
	// Serial pins
	input  wire logic         spi_cs_n_i,
	input  wire logic         spi_sclk_i,
	input  wire logic         spi_mosi_i,
	output logic              spi_miso_o,
	output logic              spi_miso_oe_o,
	// Motion pins and status
	input  wire logic         dir_pin_i,
	input  wire logic         step_pulse_input_i,
	input  wire logic [31:0]  status_i,
	// Decoded outputs
	output ssc_ctrl_type      ctrl_o,
	output logic              direction_ccw_o,
	output logic              step_advance_o
);
	logic       rst_s1_reg, rst_s2_reg;
	logic [2:0] s1_reg, s2_reg;
	logic [1:0] step_s1_reg, step_s2_reg;
	ssc_serial_type pin;
	logic sclk_d_reg, cs_d_reg, step_d_reg;
	logic rise, fall, cs_rise, step_dir_s, step_raw_s;

	// Reset release and pin synchronisers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	wire rst_n = rst_s2_reg;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg      <= 3'h4;
			s2_reg      <= 3'h4;
			step_s1_reg <= 2'h0;
			step_s2_reg <= 2'h0;
			sclk_d_reg  <= 1'b0;
			cs_d_reg    <= 1'b1;
			step_d_reg  <= 1'b0;
		end else if (clk_en_i) begin
			s1_reg      <= {spi_cs_n_i, spi_sclk_i, spi_mosi_i};
			s2_reg      <= s1_reg;
			step_s1_reg <= {dir_pin_i, step_pulse_input_i};
			step_s2_reg <= step_s1_reg;
			sclk_d_reg  <= pin.sclk;
			cs_d_reg    <= pin.cs_n;
			step_d_reg  <= step_raw_s;
		end
	end
	assign pin        = s2_reg;
	assign step_dir_s = step_s2_reg[1];
	assign step_raw_s = step_s2_reg[0];
	assign rise    = clk_en_i & ~pin.cs_n & pin.sclk & ~sclk_d_reg;
	assign fall    = clk_en_i & ~pin.cs_n & ~pin.sclk & sclk_d_reg;
	assign cs_rise = clk_en_i & pin.cs_n & ~cs_d_reg;

	// Register bank and serial engine state
	logic [7:0] regs_reg [5];
	logic [7:0] regs_next [5];
	logic [7:0] rx_reg, rx_next, tx_reg, tx_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [4:0] addr_reg, addr_next;
	logic       wr_reg, wr_next, ovf_reg, ovf_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [31:0] stat_reg, stat_next;
	logic [7:0] rx_full;
	logic [4:0] last_addr;

	function automatic int idx_of(input logic [4:0] a);
		unique case (a)
			ADDR_WATCHDOG_CONTROL:  idx_of = 0;
			ADDR_STEP_CURRENT_CTRL: idx_of = 1;
			ADDR_DIRECTION_PWM:     idx_of = 2;
			ADDR_DRIVER_SLEEP_LA:   idx_of = 3;
			ADDR_PWM_STROBE:        idx_of = 4;
			default:                idx_of = -1;
		endcase
	endfunction : idx_of

	function automatic logic [7:0] mask_of(input int i);
		unique case (i)
			0:       mask_of = MASK_WATCHDOG;
			1:       mask_of = MASK_STEP_CURRENT;
			2:       mask_of = MASK_DIRECTION_PWM;
			3:       mask_of = MASK_DRIVER_SLEEP;
			default: mask_of = MASK_PWM_STROBE;
		endcase
	endfunction : mask_of

	function automatic logic [7:0] read_of(input logic [4:0] a,
		input logic [31:0] st);
		int i;
		i = idx_of(a);
		if (i >= 0)
			read_of = regs_reg[i];
		else if (a >= ADDR_STATUS_FIRST && a <= ADDR_STATUS_LAST)
			read_of = st[8*(a-ADDR_STATUS_FIRST) +: 8];
		else
			read_of = 8'h00;
	endfunction : read_of

	assign rx_full   = {rx_reg[6:0], pin.mosi};
	assign last_addr = rx_reg[4:0];

	always_comb begin
		int i;
		i          = idx_of(addr_reg);
		rx_next    = rx_reg;
		tx_next    = tx_reg;
		cnt_next   = cnt_reg;
		addr_next  = addr_reg;
		wr_next    = wr_reg;
		ovf_next   = ovf_reg;
		wdata_next = wdata_reg;
		stat_next  = stat_reg;
		for (int k = 0; k < 5; k++)
			regs_next[k] = regs_reg[k];
		if (pin.cs_n)
			stat_next = status_i; // [R03]
		if (rise) begin
			rx_next = rx_full;
			if (cnt_reg == 5'(WRITE_PACKET_BITS))
				ovf_next = 1'b1;
			else
				cnt_next = cnt_reg + 5'h01;
			if (cnt_reg == 5'(BITS_PER_BYTE - 1)) begin
				wr_next   = rx_full[7]; // [R16]
				addr_next = rx_full[4:0]; // [R16]
			end
			if (cnt_reg == 5'(WRITE_PACKET_BITS - 1))
				wdata_next = rx_full;
		end
		if (fall) begin
			if (cnt_reg[2:0] == 3'h0 && cnt_reg != 5'h00) begin
				// Byte boundary: point at last received address
				tx_next = read_of(cnt_reg == 5'(BITS_PER_BYTE) ?
					last_addr : addr_reg, stat_reg); // [R04] [R01] [R02]
				if (cnt_reg == 5'(BITS_PER_BYTE))
					addr_next = last_addr;
			end else begin
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
		if (cs_rise) begin
			if (wr_reg && cnt_reg == 5'(WRITE_PACKET_BITS) && !ovf_reg
				&& i >= 0) begin // [R17]
				regs_next[i] = wdata_reg & mask_of(i); // [R18] [R20] [R05]
			end
			cnt_next = 5'h00;
			ovf_next = 1'b0;
			wr_next  = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < 5; k++)
				regs_reg[k] <= CTRL_RESET_VALUE; // [R05]
			rx_reg    <= 8'h00;
			tx_reg    <= 8'h00;
			cnt_reg   <= 5'h00;
			addr_reg  <= 5'h00;
			wr_reg    <= 1'b0;
			ovf_reg   <= 1'b0;
			wdata_reg <= 8'h00;
			stat_reg  <= 32'h0000_0000;
		end else if (clk_en_i) begin
			for (int k = 0; k < 5; k++)
				regs_reg[k] <= regs_next[k];
			rx_reg    <= rx_next;
			tx_reg    <= tx_next;
			cnt_reg   <= cnt_next;
			addr_reg  <= addr_next;
			wr_reg    <= wr_next;
			ovf_reg   <= ovf_next;
			wdata_reg <= wdata_next;
			stat_reg  <= stat_next;
		end
	end

	assign spi_miso_o    = tx_reg[7];
	assign spi_miso_oe_o = ~pin.cs_n;

	// Field decoding
	logic [4:0] mask_cyc, comp_cyc;
	always_comb begin
		unique case (regs_reg[4][5:4])
			2'h0: mask_cyc = MASK_TIME_00; // [R13]
			2'h1: mask_cyc = MASK_TIME_01;
			2'h2: mask_cyc = MASK_TIME_10;
			2'h3: mask_cyc = MASK_TIME_11;
		endcase
		unique case (regs_reg[4][1:0])
			2'h0: comp_cyc = COMP_TIME_00; // [R15]
			2'h1: comp_cyc = COMP_TIME_01;
			2'h2: comp_cyc = COMP_TIME_10;
			2'h3: comp_cyc = COMP_TIME_11;
		endcase
	end

	always_comb begin
		ctrl_o.watchdog_enable      = regs_reg[0][7];
		ctrl_o.watchdog_timeout_sel = regs_reg[0][6:3];
		ctrl_o.watchdog_timeout_ms  = 10'(WATCHDOG_BASE_MS)
			* (10'(regs_reg[0][6:3]) + 10'h001); // [R19]
		ctrl_o.step_resolution_sel  = regs_reg[1][7:5];
		ctrl_o.peak_current_sel     = regs_reg[1][4:0];
		ctrl_o.slope_sel            = ssc_slope_type'(regs_reg[2][1:0]); // [R08]
		ctrl_o.pwm_double_freq      = regs_reg[2][3]; // [R11]
		ctrl_o.pwm_jitter_en        = regs_reg[2][2];
		ctrl_o.load_angle_transparent  = ~regs_reg[3][4]; // [R09]
		ctrl_o.load_angle_gain_quarter = regs_reg[3][5]; // [R10]
		ctrl_o.driver_enable        = regs_reg[3][7]; // [R12]
		ctrl_o.sleep_enable         = regs_reg[3][6];
		ctrl_o.pwm_mode_sel         = regs_reg[4][7:6];
		ctrl_o.mask_comparator_cycles = mask_cyc;
		ctrl_o.switch_duty_percent  = regs_reg[4][2] ?
			DUTY_SWITCH_1 : DUTY_SWITCH_0; // [R14]
		ctrl_o.comp_bridge_cycles   = comp_cyc;
	end

	assign direction_ccw_o = step_dir_s ^ regs_reg[2][7]; // [R06]
	assign step_advance_o  = clk_en_i & (regs_reg[2][6] ?
		(step_d_reg & ~step_raw_s) : (~step_d_reg & step_raw_s)); // [R07]

	// Assertions
	commit_on_rise_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(clk_en_i && !cs_rise) |=> $stable(regs_reg[1]))
		else $error("Control register changed without select rise"); // [R18]
	unused_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(regs_reg[0][2:0] == 3'h0 && regs_reg[3][3:0] == 4'h0))
		else $error("Unused control bits nonzero"); // [R20]
	dir_xor_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		direction_ccw_o == (step_dir_s != regs_reg[2][7]))
		else $error("Direction not pin xor invert"); // [R06]
	step_edge_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		step_advance_o |-> (step_raw_s == !regs_reg[2][6]))
		else $error("Step advanced on wrong edge"); // [R07]
	status_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(clk_en_i && !pin.cs_n) |=> $stable(stat_reg))
		else $error("Status changed while selected"); // [R03]
	tx_load_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(fall && cnt_reg == 5'(BITS_PER_BYTE)) |=>
		tx_reg == read_of(last_addr, stat_reg))
		else $error("Transmit buffer not loaded at byte end"); // [R04]
	short_write_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		(cs_rise && cnt_reg != 5'(WRITE_PACKET_BITS)) |=>
		$stable(regs_reg[2]))
		else $error("Short packet altered a register"); // [R17]
	watchdog_ms_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		ctrl_o.watchdog_timeout_ms >= 10'd32 &&
		ctrl_o.watchdog_timeout_ms <= 10'd512)
		else $error("Watchdog timeout out of range"); // [R19]
	driver_en_a: assert property (@(posedge clock_i) disable iff (!rst_n)
		ctrl_o.driver_enable == regs_reg[3][7])
		else $error("Driver enable mismatch"); // [R12]
endmodule : ssc_regs

/* File: ssc_regs_tb.sv */
// Self-checking bench of the stepper control-register bank
`timescale 1ns/10ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
	err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
	end end
module ssc_regs_tb;
	import ssc_pkg::*;
	logic         clock_i, rst_n_i, cs_n, sclk, mosi, miso, miso_oe;
	logic         dir_pin, step_pin, dir_ccw, step_adv, stale_ok;
	logic [31:0]  status, seed, r;
	logic [7:0]   regs [0:31];
	logic [7:0]   stale;
	ssc_ctrl_type ctrl;
	int           err_count = 0, comparisons = 0, cyc = 0, steps = 0;
	wire logic    miso_w = miso_oe ? miso : 1'b1;
	ssc_regs i_ssc_regs (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.clk_en_i(1'b1), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
		.dir_pin_i(dir_pin), .step_pulse_input_i(step_pin),
		.status_i(status), .ctrl_o(ctrl), .direction_ccw_o(dir_ccw),
		.step_advance_o(step_adv));
	ssc_spi_master i_ssc_spi_master (.clock_i(clock_i), .cs_n_o(cs_n),
		.sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_w));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [7:0] mk(input logic [4:0] a);
		case (a)
			5'h00: return MASK_WATCHDOG;
			5'h01: return MASK_STEP_CURRENT;
			5'h02: return MASK_DIRECTION_PWM;
			5'h03: return MASK_DRIVER_SLEEP;
			5'h08: return MASK_PWM_STROBE;
			default: return 8'h00;
		endcase
	endfunction : mk
	function automatic logic [7:0] rexp(input logic [4:0] a);
		if (a >= ADDR_STATUS_FIRST && a <= ADDR_STATUS_LAST) begin
			return status[8 * (a - 4) +: 8];
		end
		return regs[a];
	endfunction : rexp
	function automatic logic [4:0] tm(input logic [1:0] c);
		return (c == 2'h3) ? 5'h13 : 5'h04 + 5'h04 * c;
	endfunction : tm
	task automatic ck_ctrl();
		`CHK("wen", regs[0][7], ctrl.watchdog_enable)
		`CHK("wms", 10'(32 * (regs[0][6:3] + 1)), ctrl.watchdog_timeout_ms)
		`CHK("cr0", regs[1], {ctrl.step_resolution_sel, ctrl.peak_current_sel})
		`CHK("slope", regs[2][1:0], ctrl.slope_sel)
		`CHK("pwmf", regs[2][3], ctrl.pwm_double_freq)
		`CHK("lat", ~regs[3][4], ctrl.load_angle_transparent)
		`CHK("lag", regs[3][5], ctrl.load_angle_gain_quarter)
		`CHK("drv", regs[3][7], ctrl.driver_enable)
		`CHK("wsel", regs[0][6:3], ctrl.watchdog_timeout_sel)
		`CHK("pwmj", regs[2][2], ctrl.pwm_jitter_en)
		`CHK("slp", regs[3][6], ctrl.sleep_enable)
		`CHK("pmode", regs[8][7:6], ctrl.pwm_mode_sel)
		`CHK("mask", tm(regs[8][5:4]), ctrl.mask_comparator_cycles)
		`CHK("duty", regs[8][2] ? 7'h4b : 7'h56, ctrl.switch_duty_percent)
		`CHK("comp", tm(regs[8][1:0]), ctrl.comp_bridge_cycles)
	endtask : ck_ctrl
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input int nb = 16);
		logic [31:0] q, v;
		logic [7:0]  old;
		old = rexp(a);
		v = {16'h0, 3'b100, a, d};
		v = (nb > 16) ? v << 1 : v >> (16 - nb);
		i_ssc_spi_master.sel();
		i_ssc_spi_master.shift(nb, v, q);
		if (nb == 16) begin
			if (stale_ok) `CHK("wr_b1", stale, q[15:8])
			`CHK("wr_old", old, q[7:0])
		end
		ck_ctrl();
		i_ssc_spi_master.desel();
		if (nb == 16) regs[a] = d & mk(a);
		stale = old;
		stale_ok = (nb == 16);
		ck_ctrl();
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic chg);
		logic [31:0] q;
		logic [7:0]  old;
		old = rexp(a);
		i_ssc_spi_master.sel();
		if (chg) status = xs();
		i_ssc_spi_master.shift(16, {19'h0, a, 8'h00}, q);
		if (stale_ok) `CHK("rd_b1", stale, q[15:8])
		`CHK("rd_val", old, q[7:0])
		i_ssc_spi_master.desel();
		stale = old;
		stale_ok = 1'b1;
	endtask : rd
	task automatic print_verdict();
		$display("Errors %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict
	// Step pulses counted mid-cycle, away from the edge that launches them
	always @(negedge clock_i) begin
		if (step_adv === 1'b1) steps++;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		seed = 32'h0000_2167;
		rst_n_i = 1'b0;
		dir_pin = 1'b0;
		step_pin = 1'b0;
		status = xs();
		for (int i = 0; i < 32; i++) regs[i] = 8'h00;
		stale = 8'h00;
		stale_ok = 1'b1;
		repeat (16) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clock_i);
		ck_ctrl();
		for (int i = 0; i < 10; i++) rd(5'(i), 1'b0);
		for (int i = 0; i < 4; i++) begin
			r = i;
			wr(5'h02, {r[1:0], 2'b11, r[0], r[1], r[1:0]});
			rd(5'h02, 1'b0);
			wr(5'h08, {r[1:0], r[1:0], 1'b1, r[0], r[1:0]});
			wr(5'h03, {r[1:0], r[0], r[1], 4'hf});
			wr(5'h00, {r[0], r[1], r[0], r[1], r[0], 3'h7});
			dir_pin = r[0];
			repeat (6) @(negedge clock_i);
			`CHK("ccw", r[0] ^ r[1], dir_ccw)
			steps = 0;
			step_pin = 1'b1;
			repeat (8) @(negedge clock_i);
			`CHK("rise", (r[0] ? 0 : 1), steps)
			step_pin = 1'b0;
			repeat (8) @(negedge clock_i);
			`CHK("fall", 1, steps)
		end
		wr(5'h02, 8'h5a, 15);
		wr(5'h02, 8'ha5, 17);
		rd(5'h02, 1'b0);
		wr(5'h1f, 8'hff);
		wr(5'h05, 8'hff);
		rd(5'h1f, 1'b0);
		rd(5'h05, 1'b1);
		repeat (30) begin
			r = xs();
			wr({1'b0, r[3:0]}, r[15:8]);
			r = xs();
			rd({1'b0, r[3:0]}, r[4]);
		end
		print_verdict();
	end
endmodule : ssc_regs_tb

/* File: ssc_spi_master.sv */
// Serial bus master model for the control-register bank
`timescale 1ns/10ps
module ssc_spi_master (
	// Clock
	input  wire logic clock_i,
	// Serial pins
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b1;
	end
	task automatic pause(input int n);
		repeat (n) @(negedge clock_i);
	endtask : pause
	task automatic sel();
		pause(1);
		cs_n_o = 1'b0;
		pause(4);
	endtask : sel
	// Shifts n bits MSB first; clock idles low outside frames
	task automatic shift(input int n, input logic [31:0] d,
		output logic [31:0] q);
		q = '0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = d[i];
			pause(4);
			sclk_o = 1'b1;
			q = {q[30:0], miso_i};
			pause(4);
			sclk_o = 1'b0;
		end
	endtask : shift
	// Released data line no longer shows the last bit
	task automatic desel();
		pause(4);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		pause(8);
	endtask : desel
endmodule : ssc_spi_master
